// *** cspr_pkg.sv ***
// shared constants for the cpu status word and power control registers
package cspr_pkg;
  // direct special function addresses
  localparam logic [7:0] STATUS_ADDR       = 8'hD0;
  localparam logic [7:0] POWER_ADDR        = 8'h87;
  // bit-address group of the status word (bit address 0xD0..0xD7 >> 3)
  localparam logic [4:0] STATUS_BIT_GROUP  = 5'h1A;
  // power-on values
  localparam logic [7:0] STATUS_RESET      = 8'h00;
  localparam logic [7:0] POWER_RESET       = 8'h00;
  // status word field positions
  localparam int         CARRY_POS         = 7;
  localparam int         AUX_CARRY_POS     = 6;
  localparam int         USER_ZERO_POS     = 5;
  localparam int         BANK_HI_POS       = 4;
  localparam int         BANK_LO_POS       = 3;
  localparam int         WRAP_POS          = 2;
  localparam int         USER_ONE_POS      = 1;
  localparam int         PARITY_POS        = 0;
  // power control field positions
  localparam int         BAUD_DOUBLER_POS  = 7;
  localparam int         SERIAL_WAKE_POS   = 6;
  localparam int         EXT0_WAKE_POS     = 5;
  localparam int         STROBE_OFF_POS    = 4;
  localparam int         SPARE_ONE_POS     = 3;
  localparam int         SPARE_ZERO_POS    = 2;
  localparam int         SLEEP_POS         = 1;
  localparam int         HALT_POS          = 0;
  // value read back from an address this block does not own
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;
endpackage

// *** cspr_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module cspr_sync #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // meta_reg is read by sync_out only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= INIT;
      sync_out <= INIT;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // cspr_sync

// *** cspr_regs.sv ***
// cpu status word and power control registers of the core
// How it works
// - status word sits at D0H, resets to 00H except bit 0, which follows accumulator parity, bit addressable
// - two bank select bits pick working register bank 0 to 3 in binary
// - carry, aux carry, wrap, parity track the core; two user flags hold writes
// - power control sits at 87H, resets to 00H, byte access only
// - power control bit 7 doubles the serial baud rate
// - power control bit 6 lets serial interfaces wake from power-down
// - power control bit 5 lets external interrupt 0 wake from power-down
// - bit 4 kills latch strobe, bits 3-2 spare, bit 1 sleep, bit 0 halt
// - status bits top-down: carry, aux, user0, bank hi, bank lo, wrap, user1, parity
`timescale 1ns/1ps
module cspr_regs (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // byte access over direct special function addressing
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  output logic            sfr_hit,
  // single bit access
  input  wire logic [7:0] bit_addr,
  input  wire logic       bit_wr,
  input  wire logic       bit_rd,
  input  wire logic       bit_wdata,
  output logic            bit_rdata,
  output logic            bit_hit,
  // flag updates from the arithmetic unit
  input  wire logic       alu_carry_we,
  input  wire logic       alu_carry,
  input  wire logic       alu_aux_we,
  input  wire logic       alu_aux,
  input  wire logic       alu_wrap_we,
  input  wire logic       alu_wrap,
  input  wire logic [7:0] accumulator,
  // power mode sequencer
  input  wire logic       power_exit,
  // serial baud timing
  input  wire logic       baud_tick,
  output logic            serial_baud_tick,
  // wake sources
  input  wire logic       serial_irq,
  input  wire logic       ext_irq0_n,
  output logic            wake_irq,
  // decoded controls
  output logic [1:0]      bank_select,
  output logic [7:0]      cpu_status_word,
  output logic            baud_doubler,
  output logic            latch_strobe_disable,
  output logic            sleep_request,
  output logic            halt_request
);
  typedef struct packed {
    logic       carry_flag;
    logic       aux_carry_flag;
    logic       user_flag_zero;
    logic [1:0] bank;
    logic       arith_wrap_flag;
    logic       user_flag_one;
    logic [7:0] power_control;
    logic       baud_phase;
    logic [7:0] rdata;
    logic       rhit;
    logic       rbit;
    logic       rbit_hit;
    logic       wake;
  } cspr_state_type;

  cspr_state_type state_reg;
  cspr_state_type state_next;
  logic           ext0_sync;
  logic           parity;

  // pin is low-active and foreign to mclk
  cspr_sync #(.WIDTH(1), .INIT(1'b1)) ext0_sync_u (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (ext_irq0_n),
    .sync_out (ext0_sync)
  );

  function automatic logic [7:0] status_byte(input cspr_state_type s, input logic p);
    logic [7:0] b;
    b = 8'h00;
    b[cspr_pkg::CARRY_POS]     = s.carry_flag;
    b[cspr_pkg::AUX_CARRY_POS] = s.aux_carry_flag;
    b[cspr_pkg::USER_ZERO_POS] = s.user_flag_zero;
    b[cspr_pkg::BANK_HI_POS]   = s.bank[1];
    b[cspr_pkg::BANK_LO_POS]   = s.bank[0];
    b[cspr_pkg::WRAP_POS]      = s.arith_wrap_flag;
    b[cspr_pkg::USER_ONE_POS]  = s.user_flag_one;
    b[cspr_pkg::PARITY_POS]    = p;
    return b;
  endfunction

  function automatic logic status_bit_hit(input logic [7:0] a);
    return a[7:3] == cspr_pkg::STATUS_BIT_GROUP;
  endfunction

  assign parity = ^accumulator;

  always_comb begin
    logic [7:0] sw;
    sw = status_byte(state_reg, parity);
    state_next = state_reg;
    // a sequencer exit clears the mode bits; a write this same cycle still wins
    if (power_exit) begin
      state_next.power_control[cspr_pkg::SLEEP_POS] = 1'b0;
      state_next.power_control[cspr_pkg::HALT_POS]  = 1'b0;
    end
    // byte writes; the parity bit in the written byte is dropped
    if (sfr_wr && sfr_addr == cspr_pkg::STATUS_ADDR) begin
      state_next.carry_flag      = sfr_wdata[cspr_pkg::CARRY_POS];
      state_next.aux_carry_flag  = sfr_wdata[cspr_pkg::AUX_CARRY_POS];
      state_next.user_flag_zero  = sfr_wdata[cspr_pkg::USER_ZERO_POS];
      state_next.bank            = {sfr_wdata[cspr_pkg::BANK_HI_POS],
                                    sfr_wdata[cspr_pkg::BANK_LO_POS]};
      state_next.arith_wrap_flag = sfr_wdata[cspr_pkg::WRAP_POS];
      state_next.user_flag_one   = sfr_wdata[cspr_pkg::USER_ONE_POS];
    end else if (sfr_wr && sfr_addr == cspr_pkg::POWER_ADDR) begin
      state_next.power_control = sfr_wdata;
    end
    // single bit writes reach the status word only, never power control
    if (bit_wr && status_bit_hit(bit_addr)) begin
      case (bit_addr[2:0])
        3'h7:    state_next.carry_flag      = bit_wdata;
        3'h6:    state_next.aux_carry_flag  = bit_wdata;
        3'h5:    state_next.user_flag_zero  = bit_wdata;
        3'h4:    state_next.bank[1]         = bit_wdata;
        3'h3:    state_next.bank[0]         = bit_wdata;
        3'h2:    state_next.arith_wrap_flag = bit_wdata;
        3'h1:    state_next.user_flag_one   = bit_wdata;
        // bit 0 is parity, owned by hardware; a byte write this cycle must survive
        default: ;
      endcase
    end
    // the arithmetic unit wins over a software write in the same cycle
    if (alu_carry_we) begin
      state_next.carry_flag = alu_carry;
    end
    if (alu_aux_we) begin
      state_next.aux_carry_flag = alu_aux;
    end
    if (alu_wrap_we) begin
      state_next.arith_wrap_flag = alu_wrap;
    end
    // without doubling only every second tick passes
    if (baud_tick) begin
      state_next.baud_phase = ~state_reg.baud_phase;
    end
    // reads return one cycle later, sampled before this cycle's write
    if (sfr_rd && sfr_addr == cspr_pkg::STATUS_ADDR) begin
      state_next.rdata = sw;
      state_next.rhit  = 1'b1;
    end else if (sfr_rd && sfr_addr == cspr_pkg::POWER_ADDR) begin
      state_next.rdata = state_reg.power_control;
      state_next.rhit  = 1'b1;
    end else if (sfr_rd) begin
      state_next.rdata = cspr_pkg::UNMAPPED_READ;
      state_next.rhit  = 1'b0;
    end
    if (bit_rd && status_bit_hit(bit_addr)) begin
      state_next.rbit     = sw[bit_addr[2:0]];
      state_next.rbit_hit = 1'b1;
    end else if (bit_rd) begin
      state_next.rbit     = 1'b0;
      state_next.rbit_hit = 1'b0;
    end
    state_next.wake = state_reg.power_control[cspr_pkg::SLEEP_POS] &
                      ((state_reg.power_control[cspr_pkg::SERIAL_WAKE_POS] & serial_irq) |
                       (state_reg.power_control[cspr_pkg::EXT0_WAKE_POS] & ~ext0_sync));
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{carry_flag: 1'b0, aux_carry_flag: 1'b0, user_flag_zero: 1'b0,
                     bank: 2'h0, arith_wrap_flag: 1'b0, user_flag_one: 1'b0,
                     power_control: cspr_pkg::POWER_RESET, baud_phase: 1'b0,
                     rdata: 8'h00, rhit: 1'b0, rbit: 1'b0, rbit_hit: 1'b0,
                     wake: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign sfr_rdata            = state_reg.rdata;
  assign sfr_hit              = state_reg.rhit;
  assign bit_rdata            = state_reg.rbit;
  assign bit_hit              = state_reg.rbit_hit;
  assign cpu_status_word      = status_byte(state_reg, parity);
  assign bank_select          = state_reg.bank;
  assign baud_doubler         = state_reg.power_control[cspr_pkg::BAUD_DOUBLER_POS];
  assign latch_strobe_disable = state_reg.power_control[cspr_pkg::STROBE_OFF_POS];
  assign sleep_request        = state_reg.power_control[cspr_pkg::SLEEP_POS];
  assign halt_request         = state_reg.power_control[cspr_pkg::HALT_POS];
  assign serial_baud_tick     = baud_tick & (baud_doubler | state_reg.baud_phase);
  assign wake_irq             = state_reg.wake;

  // checks
  status_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sfr_wr && sfr_addr == cspr_pkg::STATUS_ADDR && !bit_wr &&
    !alu_carry_we && !alu_aux_we && !alu_wrap_we
    |=> cpu_status_word[7:1] == $past(sfr_wdata[7:1]))
    else $error("status word byte write not taken");
  status_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    bit_wr && bit_addr == {cspr_pkg::STATUS_BIT_GROUP, 3'h5} && !sfr_wr
    |=> cpu_status_word[5] == $past(bit_wdata))
    else $error("status word bit write not taken");
  bank_index_a: assert property (@(posedge mclk) disable iff (!rst_n)
    bank_select == cpu_status_word[4:3])
    else $error("bank select does not match status bits");
  alu_wins_a: assert property (@(posedge mclk) disable iff (!rst_n)
    alu_carry_we |=> cpu_status_word[7] == $past(alu_carry))
    else $error("carry update lost");
  power_no_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    bit_wr && !sfr_wr && !power_exit |=> $stable(sleep_request) && $stable(baud_doubler))
    else $error("power control changed by a bit write");
  power_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sfr_rd && sfr_addr == cspr_pkg::POWER_ADDR
    |=> sfr_hit && sfr_rdata == $past(state_reg.power_control))
    else $error("power control read wrong");
  baud_halve_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !baud_doubler && serial_baud_tick && !sfr_wr ##1 baud_tick[*1] ##0 !baud_doubler
    |-> !serial_baud_tick)
    else $error("undoubled rate passed two ticks in a row");
  baud_full_a: assert property (@(posedge mclk) disable iff (!rst_n)
    baud_doubler && baud_tick |-> serial_baud_tick)
    else $error("doubled rate dropped a tick");
  wake_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wake_irq |-> $past(sleep_request) &&
      ($past(state_reg.power_control[cspr_pkg::SERIAL_WAKE_POS]) ||
       $past(state_reg.power_control[cspr_pkg::EXT0_WAKE_POS])))
    else $error("wake raised without sleep and enable");
  strobe_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sfr_wr && sfr_addr == cspr_pkg::POWER_ADDR
    |=> latch_strobe_disable == $past(sfr_wdata[4]) && halt_request == $past(sfr_wdata[0]))
    else $error("power control fields misplaced");
  parity_live_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cpu_status_word[0] == ^accumulator)
    else $error("parity flag not accumulator parity");

  sleep_cover_c: cover property (@(posedge mclk) disable iff (!rst_n)
    sleep_request ##[1:20] wake_irq);
  bank_cover_c: cover property (@(posedge mclk) disable iff (!rst_n) bank_select == 2'h3);
  doubled_cover_c: cover property (@(posedge mclk) disable iff (!rst_n)
    baud_doubler && serial_baud_tick ##1 serial_baud_tick);
endmodule // cspr_regs

// *** tb.sv ***
// self-checking testbench for the cpu status word and power control registers
`timescale 1ns/1ps
module tb;
  logic       mclk, rst_n, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, power_exit, baud_tick;
  logic       alu_carry_we, alu_carry, alu_aux_we, alu_aux, alu_wrap_we, alu_wrap;
  logic       serial_irq, ext_irq0_n, sfr_hit, bit_rdata, bit_hit, serial_baud_tick, wake_irq;
  logic       baud_doubler, latch_strobe_disable, sleep_request, halt_request;
  logic [7:0] sfr_addr, sfr_wdata, bit_addr, accumulator, sfr_rdata, cpu_status_word;
  logic [1:0] bank_select;
  logic [7:0] pc, sw, a, d;
  logic [1:0] e_bit;
  logic [7:0] probe [4] = '{8'hD0, 8'h87, 8'hD8, 8'h86};
  int         fails, total_checks, cycles, i, n, seed_word;

  cspr_regs u_dut (.mclk(mclk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_rd(bit_rd), .bit_wdata(bit_wdata),
    .bit_rdata(bit_rdata), .bit_hit(bit_hit), .alu_carry_we(alu_carry_we),
    .alu_carry(alu_carry), .alu_aux_we(alu_aux_we), .alu_aux(alu_aux),
    .alu_wrap_we(alu_wrap_we), .alu_wrap(alu_wrap), .accumulator(accumulator),
    .power_exit(power_exit), .baud_tick(baud_tick), .serial_baud_tick(serial_baud_tick),
    .serial_irq(serial_irq), .ext_irq0_n(ext_irq0_n), .wake_irq(wake_irq),
    .bank_select(bank_select), .cpu_status_word(cpu_status_word),
    .baud_doubler(baud_doubler), .latch_strobe_disable(latch_strobe_disable),
    .sleep_request(sleep_request), .halt_request(halt_request));

  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  task automatic summarize;
    if (fails == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // a hang costs at most a few thousand cycles; the whole run needs well under one thousand
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      summarize();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // status byte as software should see it; parity always follows the accumulator
  function automatic logic [7:0] status_exp();
    return {sw[7:1], ^accumulator};
  endfunction

  // every bus task starts and ends just after a falling edge, with one idle cycle
  // at the end so that a following call never re-raises a strobe in the same step
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    sfr_addr = ad;
    sfr_wdata = dt;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
    if (ad == cspr_pkg::POWER_ADDR) pc = dt;
    if (ad == cspr_pkg::STATUS_ADDR) sw = dt;
    @(negedge mclk);
  endtask

  task automatic rd_chk(input logic [7:0] ad);
    logic [7:0] e;
    logic       hit;
    hit = ad == cspr_pkg::STATUS_ADDR || ad == cspr_pkg::POWER_ADDR;
    e = (ad == cspr_pkg::STATUS_ADDR) ? status_exp() :
        (ad == cspr_pkg::POWER_ADDR) ? pc : cspr_pkg::UNMAPPED_READ;
    sfr_addr = ad;
    sfr_rd = 1'b1;
    @(negedge mclk);
    sfr_rd = 1'b0;
    chk(sfr_rdata, e);
    chk({7'h00, sfr_hit}, {7'h00, hit});
    @(negedge mclk);
  endtask

  task automatic outs;
    chk({baud_doubler, 2'b00, latch_strobe_disable, 2'b00, sleep_request, halt_request},
        pc & 8'h93);
    chk(cpu_status_word, status_exp());
    chk({6'h00, bank_select}, {6'h00, sw[4:3]});
  endtask

  // gap clear sends ticks back to back, the case where halving really bites
  task automatic baud_count(input int exp, input logic gap);
    n = 0;
    repeat (8) begin
      baud_tick = 1'b1;
      #1 n += serial_baud_tick;
      @(negedge mclk);
      if (gap) begin
        baud_tick = 1'b0;
        @(negedge mclk);
      end
    end
    baud_tick = 1'b0;
    chk(8'(n), 8'(exp));
  endtask

  // the pin is low-active: pin high here means the pin is driven low
  task automatic wake_chk(input logic [7:0] p, input logic ser, input logic pin,
                          input logic exp);
    wr(cspr_pkg::POWER_ADDR, p);
    serial_irq = ser;
    ext_irq0_n = ~pin;
    repeat (3) @(negedge mclk);
    chk({7'h00, wake_irq}, {7'h00, exp});
    serial_irq = 1'b0;
    ext_irq0_n = 1'b1;
    repeat (3) @(negedge mclk);
    chk({7'h00, wake_irq}, 8'h00);
  endtask

  initial begin
    rst_n = 1'b0;
    {sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, power_exit, baud_tick} = '0;
    {alu_carry_we, alu_carry, alu_aux_we, alu_aux, alu_wrap_we, alu_wrap, serial_irq} = '0;
    ext_irq0_n = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    bit_addr = 8'h00;
    fails = 0;
    total_checks = 0;
    cycles = 0;
    pc = 8'h00;
    sw = 8'h00;
    seed_word = $urandom(38);
    accumulator = 8'($urandom);
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    outs();
    foreach (probe[k]) rd_chk(probe[k]);
    // corner bytes first, then random traffic over both registers and stray addresses
    for (i = 0; i < 28; i++) begin
      a = (i < 4) ? ((i % 2) ? 8'h87 : 8'hD0) :
          ($urandom % 3 == 0) ? 8'hD0 : ($urandom % 2) ? 8'h87 : 8'($urandom);
      d = (i < 4) ? ((i < 2) ? 8'h00 : 8'hFF) : 8'($urandom);
      accumulator = 8'($urandom);
      wr(a, d);
      outs();
      rd_chk(a);
    end
    for (i = 0; i < 4; i++) begin
      wr(cspr_pkg::STATUS_ADDR, 8'(i << 3));
      outs();
    end
    // single-bit traffic, stray bit addresses must not reach power control
    for (i = 0; i < 30; i++) begin
      n = $urandom % 9;
      bit_addr = (n < 8) ? 8'(8'hD0 + n) : 8'(8'h80 + $urandom % 8);
      bit_wdata = 1'($urandom);
      bit_wr = 1'b1;
      @(negedge mclk);
      bit_wr = 1'b0;
      if (n > 0 && n < 8) sw[n] = bit_wdata;
      bit_rd = 1'b1;
      @(negedge mclk);
      bit_rd = 1'b0;
      e_bit = (n == 8) ? 2'b00 : (n == 0) ? {1'b1, ^accumulator} : {1'b1, sw[n]};
      chk({6'h00, bit_hit, bit_rdata}, {6'h00, e_bit});
      outs();
    end
    for (i = 0; i < 12; i++) begin
      {alu_carry, alu_aux, alu_wrap} = 3'($urandom);
      n = $urandom % 3;
      {alu_carry_we, alu_aux_we, alu_wrap_we} = 3'(4 >> n);
      if (i == 0) wr(cspr_pkg::STATUS_ADDR, 8'hFF);
      else @(negedge mclk);
      {alu_carry_we, alu_aux_we, alu_wrap_we} = 3'b000;
      if (n == 0) sw[7] = alu_carry;
      if (n == 1) sw[6] = alu_aux;
      if (n == 2) sw[2] = alu_wrap;
      outs();
      @(negedge mclk);
    end
    wr(cspr_pkg::POWER_ADDR, 8'h80);
    baud_count(8, 1'b1);
    baud_count(8, 1'b0);
    wr(cspr_pkg::POWER_ADDR, 8'h00);
    baud_count(4, 1'b1);
    baud_count(4, 1'b0);
    wr(cspr_pkg::POWER_ADDR, 8'h0F);
    power_exit = 1'b1;
    @(negedge mclk);
    pc = 8'h0C;
    outs();
    // a write in the same cycle as the sequencer exit keeps its mode bits
    sfr_addr = cspr_pkg::POWER_ADDR;
    sfr_wdata = 8'h03;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
    power_exit = 1'b0;
    pc = 8'h03;
    outs();
    @(negedge mclk);
    wake_chk(8'h42, 1'b1, 1'b0, 1'b1);
    wake_chk(8'h22, 1'b0, 1'b1, 1'b1);
    wake_chk(8'h42, 1'b0, 1'b1, 1'b0);
    wake_chk(8'h22, 1'b1, 1'b0, 1'b0);
    wake_chk(8'h02, 1'b1, 1'b1, 1'b0);
    wake_chk(8'h60, 1'b1, 1'b1, 1'b0);
    rst_n = 1'b0;
    @(negedge mclk);
    rst_n = 1'b1;
    pc = 8'h00;
    sw = 8'h00;
    outs();
    rd_chk(cspr_pkg::POWER_ADDR);
    summarize();
  end
endmodule // tb
